// File: design/power_mode_reset_control.sv
/*
 * power_mode_reset_control: idle and power-down entry and wake-up, reset sources,
 * reset-cause flags, bus strobes and port pin control per mode.
 * assumes the core presents power control writes as one-cycle strobes and that
 * the supply monitor level is synchronous; the oscillator enable gates all clocks
 * outside this block, which itself keeps running on ref_clk_i.
 */
// Behaviour
// (RQ1) writing power control bit 0 asks for idle after that instruction
// (RQ2) idle stops only the cpu clock; peripherals stay clocked
// (RQ3) idle holds both strobes high and ports frozen
// (RQ4) enabled interrupt clears idle bit and resumes after the idle instruction
// (RQ5) reset out of idle restarts at the reset vector, skipping the next instruction
// (RQ6) external reset must hold the pin high at least eight clocks
// (RQ7) watchdog timeout wakes idle; reset follows 512 clocks unless restarted
// (RQ8) writing power control bit 1 enters power down, all clocks stopped
// (RQ9) power down drives both strobes low, ports show port registers
// (RQ10) reset pin high ends power down, restarts clock, runs from zero
// (RQ11) watchdog never runs nor resets in power down
// (RQ12) low enabled level-mode external interrupt with global enable wakes power down
// (RQ13) external program memory floats port 0; idle port 2 carries address
// (RQ14) reset pin sampled in fourth state; reset applied synchronously
// (RQ15) reset held while pin high and two machine cycles after
// (RQ16) external reset sets no flag of its own
// (RQ17) low supply resets; recovery runs power-on delay and sets power-on flag
// (RQ18) software clears the power-on flag after reading it
// (RQ19) reset exit from idle has no oscillator start-up delay
// (RQ20) only reset-cause flags depend on the reset source
// (RQ21) power-on reset sets power-on flag, clears watchdog flag and enable
// (RQ22) watchdog reset sets the watchdog reset flag
// (RQ23) watchdog and external resets keep the watchdog reset enable
// (RQ24) idle and power down requested together enter power down
module power_mode_reset_control
	import power_mode_pkg::*;
#(
	parameter int POR_CYCLES = POR_DELAY_CYC
)(
	input  wire logic         ref_clk_i,
	input  wire logic         reset_n_i,
	input  wire logic         reset_pin_i,
	input  wire logic         supply_ok_i,
	input  wire logic         power_control_write_i,
	input  wire logic [7:0]   power_control_wdata_i,
	input  wire logic         wdc_write_i,
	input  wire logic         wdc_por_wdata_i,
	input  wire logic         wdc_wdt_flag_wdata_i,
	input  wire logic         wdc_wdt_en_wdata_i,
	input  wire logic         wdt_restart_i,
	input  wire logic         wdt_timeout_i,
	input  wire logic         wdt_irq_enable_i,
	input  wire logic         irq_pending_i,
	input  wire logic [1:0]   ext_int_n_i,
	input  wire logic [1:0]   ext_int_enable_i,
	input  wire logic [1:0]   ext_int_level_i,
	input  wire logic         global_interrupt_enable,
	input  wire logic         ext_program_mem_i,
	input  wire logic         ale_run_i,
	input  wire logic         program_store_strobe_run_i,
	input  wire port_set_t    port_run_i,
	input  wire port_set_t    port_reg_i,
	input  wire logic [7:0]   addr_high_i,
	output logic              cpu_clk_en_o,
	output logic              periph_clk_en_o,
	output logic              osc_en_o,
	output logic              core_reset_o,
	output logic [7:0]        reset_vector_o,
	output logic              idle_bit_o,
	output logic              pd_bit_o,
	output logic              wdt_interrupt_o,
	output logic              ale_o,
	output logic              program_store_strobe,
	output port_set_t         port_o,
	output logic              port0_oe_o,
	output reset_flags_t      flags_o,
	output logic              fourth_state_o
);

	// ----------------------------------------------------------------
	// reset pin sampling
	// ----------------------------------------------------------------
	logic pin_reset;

	reset_pin_sampler u_sampler (
		.ref_clk_i      (ref_clk_i),
		.reset_n_i      (reset_n_i),
		.reset_pin_i    (reset_pin_i),
		.fourth_state_o (fourth_state_o),
		.pin_reset_o    (pin_reset)
	);

	// ----------------------------------------------------------------
	// power-on delay and watchdog reset countdown
	// ----------------------------------------------------------------
	logic [31:0]  por_cnt_q, por_cnt_d;
	logic [9:0]   wdt_cnt_q, wdt_cnt_d;
	logic         wdt_arm_q, wdt_arm_d;
	logic         wdt_reset;
	logic         por_busy;
	pm_state_t    state_q, state_d;
	reset_flags_t flags_q, flags_d;

	assign por_busy = (por_cnt_q != 32'h0);

	always_comb begin
		por_cnt_d = por_cnt_q;
		if (!supply_ok_i)
			por_cnt_d = 32'(POR_CYCLES); // see (RQ17)
		else if (por_busy)
			por_cnt_d = por_cnt_q - 32'h1;
	end

	always_comb begin
		wdt_cnt_d = wdt_cnt_q;
		wdt_arm_d = wdt_arm_q;
		if (state_q == ST_PDOWN || core_reset_o || wdt_restart_i) begin
			// no clock reaches the watchdog in power down
			wdt_arm_d = 1'b0; // see (RQ11)
			wdt_cnt_d = 10'h0;
		end else if (wdt_timeout_i && !wdt_arm_q) begin
			wdt_arm_d = 1'b1;
			wdt_cnt_d = WDT_DELAY_CYC - 10'h1; // see (RQ7)
		end else if (wdt_arm_q && wdt_cnt_q != 10'h0) begin
			wdt_cnt_d = wdt_cnt_q - 10'h1;
		end
	end

	assign wdt_reset       = wdt_arm_q && (wdt_cnt_q == 10'h0) && flags_q.watchdog_reset_enable;
	assign wdt_interrupt_o = wdt_timeout_i && wdt_irq_enable_i;

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			por_cnt_q <= 32'h0;
			wdt_cnt_q <= 10'h0;
			wdt_arm_q <= 1'b0;
		end else begin
			por_cnt_q <= por_cnt_d;
			wdt_cnt_q <= wdt_cnt_d;
			wdt_arm_q <= wdt_arm_d;
		end
	end

	// ----------------------------------------------------------------
	// power mode state machine
	// ----------------------------------------------------------------
	logic       pd_wake_int;
	logic       any_reset;
	logic [3:0] wdt_hold_q, wdt_hold_d;

	// level wake needs per-pin enable, level mode and the global enable
	always_comb begin
		pd_wake_int = 1'b0;
		for (int i = 0; i < 2; i++) begin
			if (!ext_int_n_i[i] && ext_int_enable_i[i] && ext_int_level_i[i])
				pd_wake_int = global_interrupt_enable; // see (RQ12)
		end
	end

	// watchdog reset is held for two machine cycles like a pin reset
	always_comb begin
		wdt_hold_d = wdt_hold_q;
		if (wdt_reset)
			wdt_hold_d = RESET_STRETCH_CYC;
		else if (wdt_hold_q != 4'h0)
			wdt_hold_d = wdt_hold_q - 4'h1;
	end

	assign any_reset = !supply_ok_i || por_busy || pin_reset || wdt_hold_q != 4'h0;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_POR: begin
				if (!supply_ok_i || por_busy)
					state_d = ST_POR;
				else
					state_d = ST_RUN;
			end
			ST_RESET: begin
				if (!supply_ok_i || por_busy)
					state_d = ST_POR;
				else if (!any_reset)
					state_d = ST_RUN; // see (RQ15)
			end
			ST_RUN: begin
				if (any_reset)
					state_d = (!supply_ok_i) ? ST_POR : ST_RESET;
				else if (power_control_write_i && power_control_wdata_i[PWR_PD_BIT])
					state_d = ST_PDOWN; // see (RQ8) (RQ24)
				else if (power_control_write_i && power_control_wdata_i[PWR_IDLE_BIT])
					state_d = ST_IDLE; // see (RQ1)
			end
			ST_IDLE: begin
				// clock never stopped, so reset leaves with no start-up wait
				if (any_reset)
					state_d = (!supply_ok_i) ? ST_POR : ST_RESET; // see (RQ5) (RQ19)
				else if (irq_pending_i || wdt_interrupt_o)
					state_d = ST_RUN; // see (RQ4) (RQ7)
			end
			ST_PDOWN: begin
				if (!supply_ok_i)
					state_d = ST_POR;
				else if (pin_reset)
					state_d = ST_RESET; // see (RQ10)
				else if (pd_wake_int)
					state_d = ST_RUN;
			end
			default: state_d = ST_RESET;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			state_q    <= ST_POR;
			wdt_hold_q <= 4'h0;
		end else begin
			state_q    <= state_d;
			wdt_hold_q <= wdt_hold_d;
		end
	end

	// ----------------------------------------------------------------
	// reset-cause flags
	// ----------------------------------------------------------------
	always_comb begin
		flags_d = flags_q;
		if (wdc_write_i) begin
			flags_d.por_flag              = wdc_por_wdata_i; // see (RQ18)
			flags_d.watchdog_reset_flag   = wdc_wdt_flag_wdata_i;
			flags_d.watchdog_reset_enable = wdc_wdt_en_wdata_i;
		end
		// hardware sets override a simultaneous software clear
		if (wdt_reset)
			flags_d.watchdog_reset_flag = 1'b1; // see (RQ22) (RQ23)
		if (!supply_ok_i || por_busy) begin
			flags_d.por_flag              = 1'b1; // see (RQ17) (RQ21)
			flags_d.watchdog_reset_flag   = 1'b0;
			flags_d.watchdog_reset_enable = 1'b0;
		end
		// a pin reset leaves every flag alone: see (RQ16) (RQ20)
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			flags_q <= '{por_flag: 1'b1, watchdog_reset_flag: 1'b0,
				watchdog_reset_enable: 1'b0};
		end else begin
			flags_q <= flags_d;
		end
	end

	assign flags_o = flags_q;

	// ----------------------------------------------------------------
	// clocks, strobes and pins per mode
	// ----------------------------------------------------------------
	logic      in_reset;
	port_set_t frozen_q, frozen_d;
	port_set_t port_d;
	logic      ale_d, pss_d, oe_d;
	logic      ale_q, pss_q, oe_q;
	port_set_t port_q;

	assign in_reset = (state_q == ST_POR) || (state_q == ST_RESET);

	always_comb begin
		frozen_d = frozen_q;
		if (state_q == ST_RUN && state_d == ST_IDLE)
			frozen_d = port_run_i; // latch pin states at idle entry
	end

	always_comb begin
		ale_d  = ale_run_i;
		pss_d  = program_store_strobe_run_i;
		port_d = port_run_i;
		oe_d   = 1'b1;
		case (state_d)
			ST_IDLE: begin
				ale_d  = 1'b1; // see (RQ3)
				pss_d  = 1'b1;
				port_d = frozen_d;
				if (ext_program_mem_i) begin
					port_d.p2 = addr_high_i; // see (RQ13)
					oe_d      = 1'b0;
				end
			end
			ST_PDOWN: begin
				ale_d  = 1'b0; // see (RQ9)
				pss_d  = 1'b0;
				port_d = port_reg_i;
				oe_d   = !ext_program_mem_i; // see (RQ13)
			end
			ST_POR, ST_RESET: begin
				ale_d  = 1'b1;
				pss_d  = 1'b1;
				port_d = {4{PORT_RESET_VALUE}};
				oe_d   = 1'b0;
			end
			default: ;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			frozen_q <= {4{PORT_RESET_VALUE}};
			port_q   <= {4{PORT_RESET_VALUE}};
			ale_q    <= 1'b1;
			pss_q    <= 1'b1;
			oe_q     <= 1'b0;
		end else begin
			frozen_q <= frozen_d;
			port_q   <= port_d;
			ale_q    <= ale_d;
			pss_q    <= pss_d;
			oe_q     <= oe_d;
		end
	end

	assign port_o               = port_q;
	assign ale_o                = ale_q;
	assign program_store_strobe = pss_q;
	assign port0_oe_o           = oe_q;
	assign cpu_clk_en_o         = (state_q == ST_RUN) || in_reset; // see (RQ2)
	assign periph_clk_en_o      = (state_q != ST_PDOWN);
	assign osc_en_o             = (state_q != ST_PDOWN);
	assign core_reset_o         = in_reset; // see (RQ14)
	assign reset_vector_o       = RESET_VECTOR;
	assign idle_bit_o           = (state_q == ST_IDLE);
	assign pd_bit_o             = (state_q == ST_PDOWN);

endmodule

// File: shared/power_mode_pkg.sv
/*
 * power_mode_pkg: constants, states and carriers for the power-mode and reset control.
 * assumes a 100 MHz core clock and machine cycles of four clock states.
 */
package power_mode_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS     = 10;
	localparam int          STATES_PER_MCYCLE = 4;
	localparam logic [1:0]  FOURTH_STATE_IDX  = 2'h3;
	localparam int          RESET_STRETCH_MC  = 2;
	localparam logic [3:0]  RESET_STRETCH_CYC = 4'(RESET_STRETCH_MC * STATES_PER_MCYCLE);
	localparam int          WDT_RESET_DELAY   = 512;
	localparam logic [9:0]  WDT_DELAY_CYC     = 10'(WDT_RESET_DELAY);
	localparam int          POR_DELAY_US      = 10;
	localparam int          POR_DELAY_CYC     = POR_DELAY_US * 1000 / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// power control and watchdog control bit positions
	// ----------------------------------------------------------------
	localparam int          PWR_IDLE_BIT      = 0;
	localparam int          PWR_PD_BIT        = 1;
	localparam int          WDC_POR_BIT       = 6;
	localparam int          WDC_WDT_FLAG_BIT  = 2;
	localparam int          WDC_WDT_EN_BIT    = 1;
	localparam logic [7:0]  RESET_VECTOR      = 8'h00;
	localparam logic [7:0]  PORT_RESET_VALUE  = 8'hff;

	typedef enum logic [2:0] {
		ST_POR    = 3'b000,
		ST_RESET  = 3'b001,
		ST_RUN    = 3'b010,
		ST_IDLE   = 3'b011,
		ST_PDOWN  = 3'b100
	} pm_state_t;

	typedef struct packed {
		logic [7:0] p0;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] p3;
	} port_set_t;

	typedef struct packed {
		logic       por_flag;
		logic       watchdog_reset_flag;
		logic       watchdog_reset_enable;
	} reset_flags_t;

endpackage

// File: design/reset_pin_sampler.sv
/*
 * reset_pin_sampler: samples the reset pin once per machine cycle in the fourth
 * state and stretches the internal reset after the pin falls.
 * assumes the pin is synchronous to ref_clk_i and the clock is running.
 */
module reset_pin_sampler
	import power_mode_pkg::*;
(
	input  wire logic ref_clk_i,
	input  wire logic reset_n_i,
	input  wire logic reset_pin_i,
	output logic      fourth_state_o,
	output logic      pin_reset_o
);

	logic [1:0] phase_q, phase_d;
	logic [1:0] hits_q, hits_d;
	logic [3:0] stretch_q, stretch_d;
	logic       active_q, active_d;

	always_comb begin
		phase_d   = phase_q + 2'h1;
		hits_d    = hits_q;
		stretch_d = stretch_q;
		active_d  = active_q;
		if (phase_q == FOURTH_STATE_IDX) begin // see (RQ14)
			if (reset_pin_i) begin
				// two consecutive high samples make a valid reset
				hits_d = (hits_q == 2'h2) ? 2'h2 : hits_q + 2'h1;
				if (hits_q != 2'h0)
					active_d = 1'b1;
			end else begin
				hits_d = 2'h0;
			end
		end
		if (active_q && reset_pin_i) begin
			stretch_d = RESET_STRETCH_CYC; // see (RQ15)
		end else if (active_q && !reset_pin_i) begin
			if (stretch_q == 4'h0)
				active_d = 1'b0;
			else
				stretch_d = stretch_q - 4'h1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			phase_q   <= 2'h0;
			hits_q    <= 2'h0;
			stretch_q <= 4'h0;
			active_q  <= 1'b0;
		end else begin
			phase_q   <= phase_d;
			hits_q    <= hits_d;
			stretch_q <= stretch_d;
			active_q  <= active_d;
		end
	end

	assign fourth_state_o = (phase_q == FOURTH_STATE_IDX);
	assign pin_reset_o    = active_q;

endmodule

// File: bench/power_mode_reset_control_assertions.sv
/* checker for power_mode_reset_control: mode, strobe, port and reset relations.
   assumes it is bound to the top module and sees only its ports. */
module power_mode_reset_control_assertions
	import power_mode_pkg::*;
#(
	parameter int POR_CYCLES = POR_DELAY_CYC
)(
	input wire logic       ref_clk_i,
	input wire logic       reset_n_i,
	input wire logic       reset_pin_i,
	input wire logic       supply_ok_i,
	input wire logic       power_control_write_i,
	input wire logic [7:0] power_control_wdata_i,
	input wire logic       irq_pending_i,
	input wire logic [1:0] ext_int_n_i,
	input wire logic [1:0] ext_int_enable_i,
	input wire logic [1:0] ext_int_level_i,
	input wire logic       global_interrupt_enable,
	input wire logic       ext_program_mem_i,
	input wire port_set_t  port_reg_i,
	input wire logic [7:0] addr_high_i,
	input wire logic       cpu_clk_en_o,
	input wire logic       periph_clk_en_o,
	input wire logic       osc_en_o,
	input wire logic       core_reset_o,
	input wire logic       idle_bit_o,
	input wire logic       pd_bit_o,
	input wire logic       ale_o,
	input wire logic       program_store_strobe,
	input wire port_set_t  port_o,
	input wire logic       port0_oe_o,
	input wire reset_flags_t flags_o
);
	wire logic run = cpu_clk_en_o & ~core_reset_o;
	wire logic wake_pd = |(~ext_int_n_i & ext_int_enable_i & ext_int_level_i)
		& global_interrupt_enable;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);

	property p_idle_in; run && power_control_write_i && power_control_wdata_i[1:0] == 2'h1
		|=> idle_bit_o; endproperty
	a_idle_in: assert property (p_idle_in) else $error("idle not entered");
	property p_both; run && power_control_write_i && power_control_wdata_i[1:0] == 2'h3
		|=> pd_bit_o && !idle_bit_o; endproperty
	a_both: assert property (p_both) else $error("power down not chosen");
	property p_idle_clk; idle_bit_o |-> !cpu_clk_en_o && periph_clk_en_o && osc_en_o; endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("idle clock gating");
	property p_idle_pins; idle_bit_o && $past(idle_bit_o) |->
		ale_o && program_store_strobe && $stable(port_o.p1); endproperty
	a_idle_pins: assert property (p_idle_pins) else $error("idle pins");
	property p_irq_wake; idle_bit_o && irq_pending_i |=> !idle_bit_o; endproperty
	a_irq_wake: assert property (p_irq_wake) else $error("idle not woken");
	property p_pd_clk; pd_bit_o |-> !osc_en_o && !periph_clk_en_o && !cpu_clk_en_o; endproperty
	a_pd_clk: assert property (p_pd_clk) else $error("power down clocks");
	property p_pd_pins; pd_bit_o && $past(pd_bit_o) |-> !ale_o && !program_store_strobe
		&& port_o.p1 == $past(port_reg_i.p1); endproperty
	a_pd_pins: assert property (p_pd_pins) else $error("power down pins");
	// a pin that fell on the edge its second sample was taken still ends power down
	property p_pd_hold; pd_bit_o && !wake_pd && !reset_pin_i && !$past(reset_pin_i)
		&& supply_ok_i |=> pd_bit_o; endproperty
	a_pd_hold: assert property (p_pd_hold) else $error("power down left");
	property p_pd_wake; pd_bit_o && wake_pd |=> !pd_bit_o; endproperty
	a_pd_wake: assert property (p_pd_wake) else $error("power down not woken");
	property p_float; idle_bit_o && $past(idle_bit_o) && ext_program_mem_i
		&& $past(ext_program_mem_i) |-> !port0_oe_o && port_o.p2 == $past(addr_high_i);
	endproperty
	a_float: assert property (p_float) else $error("port 0 or 2 in idle");
	property p_pin_hold; core_reset_o && reset_pin_i |=> core_reset_o; endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("reset dropped");
	property p_stretch; $fell(reset_pin_i) && core_reset_o |-> ##[1:12] !core_reset_o;
	endproperty
	a_stretch: assert property (p_stretch) else $error("reset too long");
	property p_supply; !supply_ok_i |-> ##[1:2] (core_reset_o && flags_o.por_flag); endproperty
	a_supply: assert property (p_supply) else $error("supply reset");
	property p_noflag; $rose(core_reset_o) && $past(reset_pin_i) && supply_ok_i
		|=> $stable(flags_o); endproperty
	a_noflag: assert property (p_noflag) else $error("pin reset set a flag");

	c_irq: cover property (idle_bit_o && irq_pending_i);
	c_pd: cover property (pd_bit_o && wake_pd);
	c_pin: cover property ($rose(core_reset_o) && $past(reset_pin_i));
endmodule

bind power_mode_reset_control power_mode_reset_control_assertions
	#(.POR_CYCLES(POR_CYCLES)) u_chk (.*);

// File: bench/ext_pins_model.sv
/* ext_pins_model: reset pin, external interrupt pins and supply monitor.
   assumes callers invoke its tasks right after a rising clock edge. */
module ext_pins_model (
	input  wire logic ref_clk_i,
	output logic       reset_pin_o,
	output logic [1:0] ext_int_n_o,
	output logic       supply_ok_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		reset_pin_o = 1'b0;
		ext_int_n_o = 2'h3;
		supply_ok_o = 1'b1;
	end
	// pin held across n edges; n of 8 or more is a valid reset
	task pin_reset(input int n);
		reset_pin_o <= 1'b1;
		repeat (n) @(posedge ref_clk_i);
		reset_pin_o <= 1'b0;
	endtask
	// level request held low across n edges, then released
	task int_low(input int k, input int n);
		ext_int_n_o[k] <= 1'b0;
		repeat (n) @(posedge ref_clk_i);
		ext_int_n_o[k] <= 1'b1;
	endtask
	task brown_out(input int n);
		supply_ok_o <= 1'b0;
		repeat (n) @(posedge ref_clk_i);
		supply_ok_o <= 1'b1;
	endtask
endmodule

// File: bench/power_mode_reset_control_bench.sv
/* power_mode_reset_control_bench: idle, power down, wake and reset sequences.
   assumes the checker is bound in and the far-side pins come from ext_pins_model. */
module power_mode_reset_control_bench
	import power_mode_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk_i, reset_n_i, power_control_write_i, wdc_write_i, wdt_restart_i;
	logic wdt_timeout_i, wdc_por_wdata_i, wdc_wdt_flag_wdata_i, wdc_wdt_en_wdata_i;
	logic wdt_irq_enable_i;
	logic irq_pending_i, global_interrupt_enable, ext_program_mem_i;
	logic ale_run_i, program_store_strobe_run_i, reset_pin_i, supply_ok_i;
	logic [7:0] power_control_wdata_i, addr_high_i, reset_vector_o;
	logic [1:0] ext_int_n_i, ext_int_enable_i, ext_int_level_i;
	port_set_t port_run_i, port_reg_i, port_o;
	reset_flags_t flags_o;
	logic cpu_clk_en_o, periph_clk_en_o, osc_en_o, core_reset_o, idle_bit_o, pd_bit_o;
	logic wdt_interrupt_o, ale_o, program_store_strobe, port0_oe_o, fourth_state_o;
	int bad_count = 0;
	int n_checks = 0;
	int waited;

	power_mode_reset_control #(.POR_CYCLES(4)) DUT (.*);
	ext_pins_model pins (.ref_clk_i(ref_clk_i), .reset_pin_o(reset_pin_i),
		.ext_int_n_o(ext_int_n_i), .supply_ok_o(supply_ok_i));

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	task results();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task wait_rst(input logic v);
		for (waited = 0; waited < 700; waited++) begin
			@(posedge ref_clk_i);
			#1;
			if (core_reset_o === v) return;
		end
		chk("reset_wait", v, core_reset_o);
		results();
	endtask
	task power_ctl(input logic [7:0] d);
		power_control_write_i <= 1'b1;
		power_control_wdata_i <= d;
		tick(1);
		power_control_write_i <= 1'b0;
	endtask
	task wdc(input logic [2:0] v);
		wdc_write_i <= 1'b1;
		{wdc_por_wdata_i, wdc_wdt_flag_wdata_i, wdc_wdt_en_wdata_i} <= v;
		tick(1);
		wdc_write_i <= 1'b0;
	endtask
	task timeout_pulse();
		wdt_timeout_i <= 1'b1;
		tick(1);
		wdt_timeout_i <= 1'b0;
	endtask
	task rst_exit();
		pins.pin_reset(8);
		wait_rst(1'b1);
		chk("mode_bits", 2'h0, {idle_bit_o, pd_bit_o});
		chk("osc_on", 1'b1, osc_en_o);
		chk("vector", RESET_VECTOR, reset_vector_o);
		wait_rst(1'b0);
		chk("stretch", 1'b1, waited <= 10);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_n_i = 1'b0;
		{power_control_write_i, wdc_write_i, wdt_restart_i, wdt_timeout_i} = '0;
		{wdt_irq_enable_i, wdc_por_wdata_i, wdc_wdt_flag_wdata_i, wdc_wdt_en_wdata_i} = '0;
		irq_pending_i = 1'b0;
		{global_interrupt_enable, ext_program_mem_i, ext_int_enable_i, ext_int_level_i} = '0;
		{ale_run_i, program_store_strobe_run_i} = 2'h3;
		power_control_wdata_i = 8'h00;
		addr_high_i = 8'ha5;
		port_run_i = 32'h1234_5678;
		port_reg_i = 32'h5a3c_96e1;
		tick(12);
		reset_n_i <= 1'b1;
		wait_rst(1'b0);
		chk("por_flags", 3'h4, flags_o);
		tick(1);
		wdc(3'h0);
		#1 chk("flags_clear", 3'h0, flags_o);
		tick(1);
		power_ctl(8'h01);
		#1 chk("idle", 3'h5, {idle_bit_o, cpu_clk_en_o, periph_clk_en_o});
		tick(1);
		#1 chk("idle_strobes", 2'h3, {ale_o, program_store_strobe});
		tick(1);
		irq_pending_i <= 1'b1;
		tick(1);
		irq_pending_i <= 1'b0;
		#1 chk("irq_wake", 2'h1, {idle_bit_o, cpu_clk_en_o});
		tick(1);
		ext_program_mem_i <= 1'b1;
		power_ctl(8'h01);
		tick(2);
		#1 chk("p2_address", {1'b0, addr_high_i}, {port0_oe_o, port_o.p2});
		tick(1);
		ext_program_mem_i <= 1'b0;
		rst_exit();
		chk("pin_no_flag", 3'h0, flags_o);
		tick(1);
		// four edges always hold exactly one fourth-state sample
		pins.pin_reset(4);
		tick(8);
		#1 chk("short_pulse", 1'b0, core_reset_o);
		tick(1);
		wdc(3'h1);
		wdt_irq_enable_i <= 1'b1;
		power_ctl(8'h01);
		wdt_timeout_i <= 1'b1;
		#1 chk("wdt_irq", 1'b1, wdt_interrupt_o);
		tick(1);
		wdt_timeout_i <= 1'b0;
		wait_rst(1'b1);
		chk("wdt_delay", 1'b1, waited >= 511 && waited <= 513);
		chk("wdt_flags", 3'h3, flags_o);
		wait_rst(1'b0);
		tick(1);
		wdc(3'h1);
		timeout_pulse();
		tick(100);
		wdt_restart_i <= 1'b1;
		tick(1);
		wdt_restart_i <= 1'b0;
		tick(600);
		#1 chk("restart", 4'h1, {core_reset_o, flags_o});
		tick(1);
		power_ctl(8'h03);
		tick(1);
		#1 chk("pd", 4'h8, {pd_bit_o, idle_bit_o, osc_en_o, ale_o});
		chk("pd_port1", port_reg_i.p1, port_o.p1);
		tick(1);
		timeout_pulse();
		tick(600);
		#1 chk("pd_no_wdt", 4'h9, {pd_bit_o, flags_o});
		tick(1);
		{global_interrupt_enable, ext_int_enable_i, ext_int_level_i} <= 5'h14;
		pins.int_low(0, 8);
		#1 chk("pd_edge_mode", 1'b1, pd_bit_o);
		tick(1);
		{global_interrupt_enable, ext_int_enable_i, ext_int_level_i} <= 5'h15;
		pins.int_low(0, 4);
		#1 chk("pd_int_wake", 1'b0, pd_bit_o);
		tick(1);
		ext_program_mem_i <= 1'b1;
		power_ctl(8'h02);
		#1 chk("pd_ext_pins", {1'b0, port_reg_i.p2}, {port0_oe_o, port_o.p2});
		rst_exit();
		tick(1);
		pins.brown_out(5);
		wait_rst(1'b0);
		chk("brown_flags", 3'h4, flags_o);
		waited = 0;
		repeat (8) begin
			@(posedge ref_clk_i);
			#1 waited += fourth_state_o;
		end
		chk("fourth_state", 2, waited);
		results();
	end
endmodule
